// ### logic/cgsel_regs.vh
// Constants of the clock select and gating block
`ifndef CGSEL_REGS_VH
`define CGSEL_REGS_VH
// Two-wire device address and byte indices
`define CGSEL_DEV_ADDR 7'h69
`define CGSEL_BYTE_FUNC 3'h0
`define CGSEL_BYTE_CPU 3'h1
`define CGSEL_BYTE_PCI 3'h2
`define CGSEL_BYTE_MEM 3'h3
`define CGSEL_BYTE_REF 3'h5
// Field positions in the function byte
`define CGSEL_BIT_STOPSEL 7
`define CGSEL_BIT_SWSEL 3
// Reset values
`define CGSEL_RST_FUNC 8'h00
`define CGSEL_RST_CPU 8'h0F
`define CGSEL_RST_PCI 8'hFF
`define CGSEL_RST_MEM 8'h3F
`define CGSEL_RST_REF 8'h07
// Spread modes
`define CGSEL_SPR_C035 2'h0
`define CGSEL_SPR_D050 2'h1
`define CGSEL_SPR_C060 2'h2
`define CGSEL_SPR_NONE 2'h3
// Power-down latency, ns, and core clock period, ns
`define CGSEL_PD_LAT_NS 3000000
`define CGSEL_CLK_NS 8
`endif

// ### logic/cgsel_gate.v
// Glitch-free clock gate for one output
`timescale 1ns/1ps
module cgsel_gate (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire clk_src_in,
  input wire enable_in,
  output reg gated_out
);
  reg en_r;
  // Enable changes only while source is low, so no runt high pulse
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      en_r <= 1'b0;
    end else if (!clk_src_in) begin
      en_r <= enable_in; // RULE_17
    end
  end
  // Held low while disabled
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      gated_out <= 1'b0;
    end else begin
      gated_out <= clk_src_in & en_r; // RULE_15
    end
  end
endmodule

// ### logic/cgsel_top.v
// Clock select and gating control core
// What this block does
// [RULE_01] Latch straps once after power-on reset
// [RULE_02] Strap bit a picks CPU; bits b and c spread
// [RULE_03] Decode five-bit software select code
// [RULE_04] Codes 11xxx repeat the strap mapping
// [RULE_05] Bit three picks straps or register code
// [RULE_06] Memory stop low holds gated memory clocks
// [RULE_07] PCI stop low holds gated PCI clocks
// [RULE_08] Memory clocks copy the buffer input
// [RULE_09] Latched rate select picks 24 or 48
// [RULE_10] Clock stop halts all but CPU pair
// [RULE_11] Power down stops everything within 3 ms; code waits the full 3 ms after two sync stages, so clocks stop past 3 ms
// [RULE_12] CPU stop halts only single-ended CPU clock
// [RULE_13] Reference outputs carry crystal frequency
// [RULE_14] Settings written over the two-wire port
// [RULE_15] Disabled output stays low, no switching
// [RULE_16] Latched selects load inverted into register
// [RULE_17] Gate changes only while clock is low
`timescale 1ns/1ps
`include "cgsel_regs.vh"
module cgsel_top #(
  parameter PD_CYCLES = `CGSEL_PD_LAT_NS / `CGSEL_CLK_NS
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire freq_sel_bit_a_in,
  input wire freq_sel_bit_b_in,
  input wire freq_sel_bit_c_in,
  input wire freq_sel_bit_d_in,
  input wire periph_rate_select_in,
  input wire mem_stop_n_in,
  input wire pci_clock_halt_n_in,
  input wire cpu_stop_n_in,
  input wire clock_stop_n_in,
  input wire power_down_n_in,
  input wire buffer_clk_in,
  input wire ref_clk_in,
  input wire cpu_clk_in,
  input wire pci_clk_in,
  input wire clk48_in,
  input wire clk24_in,
  input wire serial_clk_in,
  input wire serial_data_line_in,
  output wire serial_data_line_out,
  output wire serial_data_line_oe_out,
  output wire straps_oe_out,
  output wire [4:0] freq_code_out,
  output wire [1:0] spread_mode_out,
  output wire cpu_fast_out,
  output reg low_power_out,
  output wire cpu_diff_true_out,
  output wire cpu_diff_complement_out,
  output wire cpu_single_to_chipset_out,
  output wire pci_free_running_out,
  output wire pci_gated_out_zero_out,
  output wire [5:0] pci_gated_outs_upper_out,
  output wire mem_free_running_out,
  output wire [5:0] mem_gated_out,
  output wire clk48_out,
  output wire periph_selectable_out,
  output wire ref_out_two_out,
  output wire [1:0] ref_outs_low_out
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam NS = 16;
  wire [NS-1:0] raw = {freq_sel_bit_a_in, freq_sel_bit_b_in, freq_sel_bit_c_in, freq_sel_bit_d_in,
    periph_rate_select_in, mem_stop_n_in, pci_clock_halt_n_in, cpu_stop_n_in, clock_stop_n_in,
    power_down_n_in, buffer_clk_in, ref_clk_in, cpu_clk_in, pci_clk_in, serial_clk_in, serial_data_line_in};
  reg [NS-1:0] s1_r;
  reg [NS-1:0] s2_r;
  reg [1:0] ck48_s1_r;
  reg [1:0] ck48_s2_r;
  // Two stages; only the second stage is read by logic
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      s1_r <= {NS{1'b1}};
      s2_r <= {NS{1'b1}};
      ck48_s1_r <= 2'h0;
      ck48_s2_r <= 2'h0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      ck48_s1_r <= {clk48_in, clk24_in};
      ck48_s2_r <= ck48_s1_r;
    end
  end
  wire sy_a = s2_r[15];
  wire sy_b = s2_r[14];
  wire sy_c = s2_r[13];
  wire sy_d = s2_r[12];
  wire sy_rate = s2_r[11];
  wire sy_mem_n = s2_r[10];
  wire sy_pci_n = s2_r[9];
  wire sy_cpu_n = s2_r[8];
  wire sy_cstop_n = s2_r[7];
  wire sy_pd_n = s2_r[6];
  wire sy_buf = s2_r[5];
  wire sy_ref = s2_r[4];
  wire sy_cpu = s2_r[3];
  wire sy_pci = s2_r[2];
  wire sy_scl = s2_r[1];
  wire sy_sda = s2_r[0];
  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  reg [2:0] settle_r;
  reg latched_r;
  reg [3:0] strap_r;
  reg rate_r;
  // Wait for synchronisers to fill, then capture once
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      settle_r <= 3'h0;
      latched_r <= 1'b0;
      strap_r <= 4'h0;
      rate_r <= 1'b0;
    end else if (!latched_r) begin
      settle_r <= settle_r + 3'h1;
      if (settle_r == 3'h3) begin
        latched_r <= 1'b1; // RULE_01
        strap_r <= ~{sy_d, sy_c, sy_b, sy_a}; // RULE_16
        rate_r <= sy_rate; // RULE_09
      end
    end
  end
  assign straps_oe_out = latched_r; // RULE_01
  // ----------------------------------------------------------------
  // Two-wire slave, write and read of byte registers
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_ACK = 3'h2, ST_CMD = 3'h3, ST_WR = 3'h4, ST_RD = 3'h5, ST_RACK = 3'h6;
  reg [2:0] st_r;
  reg [2:0] bit_r;
  reg [7:0] sh_r;
  reg rnw_r;
  reg [1:0] phase_r;
  reg [2:0] idx_r;
  reg scl_d_r;
  reg sda_d_r;
  reg sda_drv_r;
  reg [7:0] func_r;
  reg [7:0] cpu_en_r;
  reg [7:0] pci_en_r;
  reg [7:0] mem_en_r;
  reg [7:0] ref_en_r;
  wire scl_rise = sy_scl & ~scl_d_r;
  wire scl_fall = ~sy_scl & scl_d_r;
  wire start_c = sy_scl & scl_d_r & sda_d_r & ~sy_sda;
  wire stop_c = sy_scl & scl_d_r & ~sda_d_r & sy_sda;
  wire [7:0] rd_byte = (idx_r == `CGSEL_BYTE_FUNC) ? func_r :
    (idx_r == `CGSEL_BYTE_CPU) ? cpu_en_r : (idx_r == `CGSEL_BYTE_PCI) ? pci_en_r :
    (idx_r == `CGSEL_BYTE_MEM) ? {1'b0, rate_r, mem_en_r[5:0]} :
    (idx_r == `CGSEL_BYTE_REF) ? {strap_r[0], strap_r[1], strap_r[2], strap_r[3], rate_r, ref_en_r[2:0]} : 8'h00;
  // Protocol: address, command byte, then data bytes to successive indices
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st_r <= ST_IDLE;
      bit_r <= 3'h0;
      sh_r <= 8'h00;
      rnw_r <= 1'b0;
      phase_r <= 2'h0;
      idx_r <= 3'h0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      sda_drv_r <= 1'b0;
      func_r <= `CGSEL_RST_FUNC;
      cpu_en_r <= `CGSEL_RST_CPU;
      pci_en_r <= `CGSEL_RST_PCI;
      mem_en_r <= `CGSEL_RST_MEM;
      ref_en_r <= `CGSEL_RST_REF;
    end else begin
      scl_d_r <= sy_scl;
      sda_d_r <= sy_sda;
      if (start_c) begin
        st_r <= ST_ADDR;
        bit_r <= 3'h0;
        phase_r <= 2'h0;
        sda_drv_r <= 1'b0;
      end else if (stop_c) begin
        st_r <= ST_IDLE;
        sda_drv_r <= 1'b0;
      end else begin
        case (st_r)
          ST_ADDR, ST_CMD, ST_WR: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sy_sda};
              bit_r <= bit_r + 3'h1;
              // Eighth bit in: acknowledge on the coming fall, not on the start's own fall
              if (bit_r == 3'h7) begin
                phase_r <= 2'h3;
              end
            end
            if (scl_fall && phase_r == 2'h3) begin
              if (st_r == ST_ADDR && sh_r[7:1] != `CGSEL_DEV_ADDR) begin
                st_r <= ST_IDLE;
                phase_r <= 2'h0;
              end else begin
                sda_drv_r <= 1'b1;
                st_r <= ST_ACK;
                if (st_r == ST_ADDR) begin
                  rnw_r <= sh_r[0];
                end else if (st_r == ST_CMD) begin
                  idx_r <= 3'h0;
                end else begin
                  case (idx_r) // RULE_14
                    `CGSEL_BYTE_FUNC: func_r <= sh_r; // RULE_05
                    `CGSEL_BYTE_CPU: cpu_en_r <= sh_r;
                    `CGSEL_BYTE_PCI: pci_en_r <= sh_r;
                    `CGSEL_BYTE_MEM: mem_en_r <= sh_r;
                    `CGSEL_BYTE_REF: ref_en_r <= sh_r;
                    default: ;
                  endcase
                  idx_r <= idx_r + 3'h1;
                end
                phase_r <= (st_r == ST_ADDR) ? 2'h1 : 2'h2;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              sda_drv_r <= 1'b0;
              bit_r <= 3'h0;
              if (rnw_r && phase_r == 2'h1) begin
                st_r <= ST_RD;
                sh_r <= rd_byte;
                sda_drv_r <= ~rd_byte[7];
              end else begin
                st_r <= (phase_r == 2'h1) ? ST_CMD : ST_WR;
              end
              phase_r <= 2'h0;
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              bit_r <= bit_r + 3'h1;
              sh_r <= {sh_r[6:0], 1'b0};
              sda_drv_r <= (bit_r == 3'h7) ? 1'b0 : ~sh_r[6];
              if (bit_r == 3'h7) begin
                st_r <= ST_RACK;
                idx_r <= idx_r + 3'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              st_r <= sy_sda ? ST_IDLE : ST_ACK;
              phase_r <= 2'h1;
            end
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end
  assign serial_data_line_out = 1'b0;
  assign serial_data_line_oe_out = sda_drv_r;
  // ----------------------------------------------------------------
  // Frequency selection
  // ----------------------------------------------------------------
  wire sw_sel = func_r[`CGSEL_BIT_SWSEL]; // RULE_05
  wire [4:0] sw_code = {func_r[2], func_r[1], func_r[6], func_r[5], func_r[4]}; // RULE_03
  // Stored copy is inverted; decode uses the pin levels
  wire [4:0] hw_code = {2'b11, ~strap_r[2:0]}; // RULE_02
  assign freq_code_out = sw_sel ? sw_code : hw_code; // RULE_04
  assign spread_mode_out = (freq_code_out[4:3] == 2'b11) ? freq_code_out[2:1] : `CGSEL_SPR_NONE; // RULE_03
  assign cpu_fast_out = freq_code_out[0]; // RULE_02
  // ----------------------------------------------------------------
  // Power down and output gating
  // ----------------------------------------------------------------
  localparam PDW = 20;
  reg [PDW-1:0] pd_cnt_r;
  // Count reaches low power after PD_CYCLES cycles, the whole latency bound
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pd_cnt_r <= {PDW{1'b0}};
      low_power_out <= 1'b0;
    end else if (sy_pd_n) begin
      pd_cnt_r <= {PDW{1'b0}};
      low_power_out <= 1'b0;
    end else if (pd_cnt_r == PD_CYCLES[PDW-1:0] - 1'b1 || low_power_out) begin
      low_power_out <= 1'b1; // RULE_11
    end else begin
      pd_cnt_r <= pd_cnt_r + 1'b1;
    end
  end
  wire run = ~low_power_out & ~(sy_cstop_n == 1'b0) & latched_r; // RULE_10
  wire diff_run = ~low_power_out & latched_r;
  wire mem_go = run & sy_mem_n; // RULE_06
  wire pci_go = run & sy_pci_n; // RULE_07
  wire periph_src = rate_r ? ck48_s2_r[0] : ck48_s2_r[1]; // RULE_09
  localparam NG = 23;
  wire [NG-1:0] g_src = {sy_cpu, sy_cpu, sy_cpu, sy_pci, {7{sy_pci}}, sy_buf, {6{sy_buf}},
    ck48_s2_r[1], periph_src, sy_ref, sy_ref, sy_ref}; // RULE_08 RULE_13
  wire [NG-1:0] g_en = {diff_run & cpu_en_r[1], diff_run & cpu_en_r[0],
    run & sy_cpu_n & cpu_en_r[2], // RULE_12
    run & pci_en_r[0], {7{pci_go}} & pci_en_r[7:1],
    run & mem_en_r[3], {mem_go & mem_en_r[2], mem_go & mem_en_r[2], mem_go & mem_en_r[1],
    mem_go & mem_en_r[1], mem_go & mem_en_r[0], mem_go & mem_en_r[0]},
    run & mem_en_r[5], run & mem_en_r[4], run & ref_en_r[2], run & ref_en_r[1], run & ref_en_r[0]};
  wire [NG-1:0] g_out;
  genvar gi;
  generate
    for (gi = 0; gi < NG; gi = gi + 1) begin : g_gate
      cgsel_gate u_gate (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .clk_src_in(g_src[gi]),
        .enable_in(g_en[gi]),
        .gated_out(g_out[gi])
      );
    end
  endgenerate
  // Open-drain pair shown as logic levels; complement gates the same CPU source, not inverted
  assign cpu_diff_true_out = g_out[22];
  assign cpu_diff_complement_out = g_out[21];
  assign cpu_single_to_chipset_out = g_out[20];
  assign pci_free_running_out = g_out[19];
  assign pci_gated_outs_upper_out = g_out[18:13];
  assign pci_gated_out_zero_out = g_out[12];
  assign mem_free_running_out = g_out[11];
  assign mem_gated_out = g_out[10:5];
  assign clk48_out = g_out[4];
  assign periph_selectable_out = g_out[3];
  assign ref_out_two_out = g_out[2];
  assign ref_outs_low_out = g_out[1:0];
  wire unused_ok = func_r[0] & func_r[`CGSEL_BIT_STOPSEL] & strap_r[3] & cpu_en_r[7] & ref_en_r[7];
endmodule

// ### dv/cgsel_top_asserts.sv
// Port checks for the clock select and gating core
`timescale 1ns/1ps
module cgsel_top_asserts #(
  parameter PD_CYCLES = 20
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire mem_stop_n_in,
  input wire pci_clock_halt_n_in,
  input wire cpu_stop_n_in,
  input wire clock_stop_n_in,
  input wire power_down_n_in,
  input wire serial_data_line_out,
  input wire serial_data_line_oe_out,
  input wire straps_oe_out,
  input wire low_power_out,
  input wire cpu_single_to_chipset_out,
  input wire pci_free_running_out,
  input wire pci_gated_out_zero_out,
  input wire [5:0] pci_gated_outs_upper_out,
  input wire [5:0] mem_gated_out,
  input wire ref_out_two_out,
  input wire [1:0] ref_outs_low_out
);
  // ----------------------------------------
  // Stop inputs held past sync and gate wait
  // ----------------------------------------
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_mem_held;
    !mem_stop_n_in [*8];
  endsequence
  // Slow sources stay high up to eight cycles, so the gate may wait that long
  sequence s_clk_held;
    !clock_stop_n_in [*8] ##1 !clock_stop_n_in [*8];
  endsequence
  sequence s_pci_held;
    !pci_clock_halt_n_in [*8] ##1 !pci_clock_halt_n_in [*8];
  endsequence
  sequence s_lp_held;
    low_power_out [*8] ##1 low_power_out [*8];
  endsequence
  // Cycles spent in power down, saturating so it never wraps
  logic [31:0] pd_cnt_r;
  always @(posedge core_clk_in) begin
    if (!rst_n_in || power_down_n_in)
      pd_cnt_r <= 32'h0;
    else if (pd_cnt_r < 32'hFFFF)
      pd_cnt_r <= pd_cnt_r + 32'h1;
  end
  chk_mem_halt_low: assert property (s_mem_held |-> mem_gated_out == 6'h00)
    else $error("memory clocks run while stopped");
  chk_pci_halt_low: assert property (s_pci_held
    |-> {pci_gated_out_zero_out, pci_gated_outs_upper_out} == 7'h00)
    else $error("pci clocks run while stopped");
  chk_cpu_single_halt: assert property (!cpu_stop_n_in [*8] |-> !cpu_single_to_chipset_out)
    else $error("chipset cpu clock runs while stopped");
  chk_clk_stop_quiet: assert property (s_clk_held
    |-> ref_outs_low_out == 2'h0 && !ref_out_two_out && !pci_free_running_out)
    else $error("clock stop left outputs running");
  chk_straps_kept: assert property ($rose(straps_oe_out) |=> straps_oe_out [*8])
    else $error("strap pins left output mode");
  chk_pd_latency: assert property (pd_cnt_r > PD_CYCLES + 4 |-> low_power_out)
    else $error("power down too slow");
  chk_pd_outs_low: assert property (s_lp_held
    |-> ref_outs_low_out == 2'h0 && mem_gated_out == 6'h00 && !ref_out_two_out)
    else $error("outputs run in low power");
  chk_sda_drive_low: assert property (serial_data_line_oe_out |-> !serial_data_line_out)
    else $error("serial line driven high");
endmodule

bind cgsel_top cgsel_top_asserts #(.PD_CYCLES(PD_CYCLES)) i_cgsel_top_asserts (.core_clk_in, .rst_n_in,
  .mem_stop_n_in, .pci_clock_halt_n_in, .cpu_stop_n_in, .clock_stop_n_in, .power_down_n_in,
  .serial_data_line_out, .serial_data_line_oe_out, .straps_oe_out, .low_power_out,
  .cpu_single_to_chipset_out, .pci_free_running_out, .pci_gated_out_zero_out,
  .pci_gated_outs_upper_out, .mem_gated_out, .ref_out_two_out, .ref_outs_low_out);

// ### dv/cgsel_host_model.sv
// Two-wire bus master standing in for the system controller
`timescale 1ns/1ps
module cgsel_host_model (
  input wire logic sda_oe_in,
  output logic scl_out,
  output logic sda_out
);
  logic sda_drv = 1'b1;
  int nacks = 0;
  initial scl_out = 1'b1;
  // Open drain with pull-up: high unless a party pulls low
  assign sda_out = sda_drv & ~sda_oe_in;
  // Data moves only while the link clock is low
  task automatic bit_io(input logic b);
    sda_drv = b;
    #16 scl_out = 1'b1;
    #32 scl_out = 1'b0;
    #16;
  endtask
  // Release the line and count a missing acknowledge
  task automatic ack_io();
    sda_drv = 1'b1;
    #16 scl_out = 1'b1;
    #16 nacks += sda_out;
    #16 scl_out = 1'b0;
    #16;
  endtask
  // Start, address, command byte, then bytes 0..3; 64 ns clock, still outside frames
  task automatic xfer(input logic [6:0] addr, input logic [31:0] d);
    logic [47:0] s;
    s = {addr, 1'b0, 8'h00, d};
    #2 sda_drv = 1'b0;
    #32 scl_out = 1'b0;
    #16;
    for (int i = 47; i >= 0; i--) begin
      bit_io(s[i]);
      if (i % 8 == 0) ack_io();
    end
    sda_drv = 1'b0;
    #16 scl_out = 1'b1;
    #32 sda_drv = 1'b1;
    #32;
  endtask
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the clock select and gating core
`timescale 1ns/1ps
module tb_top;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] fs = 4'h0;
  logic sel = 1'b0;
  logic [4:0] stp = 5'h1F;
  logic [3:0] cnt = 4'h0;
  logic [15:0] lfsr = 16'h3AA5;
  logic [7:0] seen, hw_exp;
  logic [4:0] cs;
  int errors = 0;
  int n_checks = 0;
  wire scl, sda, sda_oe, straps_oe, fast, lp, diff_t, single, pci_f, pci0, mem_f, c48, periph, ref_out_two;
  wire [4:0] code;
  wire [1:0] spread, refl;
  wire [5:0] pci_up, mem_g;
  logic [7:0] mask_tab [6] = '{8'hFE, 8'hFB, 8'hEF, 8'h20, 8'h00, 8'hFF};
  // ----------------------------------------
  // Clocks, sources and instances
  // ----------------------------------------
  always #4 core_clk_in = ~core_clk_in;
  // Sources kept slow so sampled copies stay clean
  always @(posedge core_clk_in) cnt <= cnt + 4'h1;
  cgsel_top #(.PD_CYCLES(20)) i_cgsel_top (.core_clk_in, .rst_n_in, .freq_sel_bit_a_in(fs[0]),
    .freq_sel_bit_b_in(fs[1]), .freq_sel_bit_c_in(fs[2]), .freq_sel_bit_d_in(fs[3]),
    .periph_rate_select_in(sel), .mem_stop_n_in(stp[0]), .pci_clock_halt_n_in(stp[1]),
    .cpu_stop_n_in(stp[2]), .clock_stop_n_in(stp[3]), .power_down_n_in(stp[4]),
    .buffer_clk_in(cnt[2]), .ref_clk_in(cnt[3]), .cpu_clk_in(cnt[2]), .pci_clk_in(cnt[3]),
    .clk48_in(cnt[2]), .clk24_in(cnt[3]), .serial_clk_in(scl), .serial_data_line_in(sda),
    .serial_data_line_out(), .serial_data_line_oe_out(sda_oe), .straps_oe_out(straps_oe),
    .freq_code_out(code), .spread_mode_out(spread), .cpu_fast_out(fast), .low_power_out(lp),
    .cpu_diff_true_out(diff_t), .cpu_diff_complement_out(), .cpu_single_to_chipset_out(single),
    .pci_free_running_out(pci_f), .pci_gated_out_zero_out(pci0), .pci_gated_outs_upper_out(pci_up),
    .mem_free_running_out(mem_f), .mem_gated_out(mem_g), .clk48_out(c48),
    .periph_selectable_out(periph), .ref_out_two_out(ref_out_two), .ref_outs_low_out(refl));
  cgsel_host_model i_host (.sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Code, spread, fast flag: 11xxx repeats strap map, others unspread
  function automatic logic [7:0] exp_sw(input logic [4:0] c);
    return {c, (c[4:3] == 2'h3) ? c[2:1] : 2'h3, c[0]};
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Which output groups toggled high over n cycles
  task automatic watch(input int n);
    seen = 8'h00;
    repeat (n) begin
      @(posedge core_clk_in);
      seen = seen | {periph | c48, ref_out_two | (|refl), diff_t, single, pci_f, pci0 | (|pci_up), mem_f, |mem_g};
    end
  endtask
  task automatic test_done();
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    test_done();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    for (int k = 0; k < 3; k++) begin
      lfsr = lfsr_next(lfsr);
      @(posedge core_clk_in);
      fs <= lfsr[3:0];
      sel <= lfsr[4];
      rst_n_in <= 1'b0;
      repeat (4) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      repeat (20) @(posedge core_clk_in);
      hw_exp = {5'h01, fs[0], fs[2:1]};
      cmp({4'h0, straps_oe, fast, spread}, hw_exp);
      fs <= ~fs;
      repeat (10) @(posedge core_clk_in);
      cmp({4'h0, straps_oe, fast, spread}, hw_exp);
    end
    for (int c = 0; c < 32; c++) begin
      cs = c[4:0];
      i_host.xfer(7'h69, {1'b0, cs[2:0], 1'b1, cs[4:3], 1'b0, 24'h0FFF3F});
      repeat (8) @(posedge core_clk_in);
      cmp({code, spread, fast}, exp_sw(cs));
    end
    cmp(i_host.nacks[7:0], 8'h00);
    // Disable pci, memory and peripheral groups; back to strap select
    i_host.xfer(7'h69, 32'h000F0000);
    watch(24);
    cmp(seen, 8'h70);
    cmp({4'h0, straps_oe, fast, spread}, hw_exp);
    // Wrong address must be ignored
    i_host.xfer(7'h6A, 32'h3E0FFF3F);
    cmp(i_host.nacks[7:0], 8'h06);
    watch(24);
    cmp({seen[7:4], straps_oe, fast, spread}, {4'h7, hw_exp[3:0]});
    i_host.xfer(7'h69, 32'h000FFF3F);
    for (int m = 0; m < 6; m++) begin
      @(posedge core_clk_in);
      stp <= ~(5'h01 << m);
      repeat (40) @(posedge core_clk_in);
      watch(24);
      cmp(seen, mask_tab[m]);
      cmp({7'h0, lp}, {7'h0, m == 4});
    end
    test_done();
  end
endmodule
